// File: pfaqr_func_mask.sv
// Clears bitmap bits that lie beyond the supported function count.
`timescale 1ns/1ps
module pfaqr_func_mask (
   // Word and its kind.
   input  wire logic [31:0]               word_in,
   input  wire logic                      is_bitmap_in,
   // Number of functions the controller supports.
   input  wire pfaqr_pkg::pfaqr_count_t   func_count_in,
   // Masked word.
   output logic      [31:0]               word_out
);

   // Only bitmaps are masked; code words pass untouched.
   always_comb begin
      if (is_bitmap_in) begin
         word_out = word_in & pfaqr_pkg::pfaqr_lowmask(func_count_in);
      end else begin
         word_out = word_in;
      end
   end

endmodule : pfaqr_func_mask

// File: pfaqr_mgmt_model.sv
// Management-side partner that takes response words, stalling at random, and logs each one.
`timescale 1ns/1ps
module pfaqr_mgmt_model (
   // Clock and stall enable.
   input  wire logic        clk_in,
   input  wire logic        stall_in,
   // Response stream.
   input  wire logic        valid_in,
   input  wire logic [7:0]  type_in,
   input  wire logic [7:0]  ofs_in,
   input  wire logic [31:0] word_in,
   input  wire logic        csum_in,
   input  wire logic        last_in,
   output logic             ready_out
);
   logic [15:0] pat = 16'h1d35;
   logic [49:0] log_q[$];
   // Ready moves only at the falling edge, so a stall may land on any word.
   always @(negedge clk_in) begin
      pat = {pat[14:0], pat[15] ^ pat[11]};
      ready_out = !stall_in | pat[0];
   end
   // Log a word on the edge that accepts it.
   always @(posedge clk_in) begin
      if (valid_in && ready_out) begin
         log_q.push_back({type_in, ofs_in, csum_in, last_in, word_in});
      end
   end
endmodule : pfaqr_mgmt_model

// File: pfaqr_params.svh
// Constants for the function-assignment query responder: codes, offsets and field values.
`ifndef PFAQR_PARAMS_SVH
`define PFAQR_PARAMS_SVH

// Command type codes accepted by this block.
`define PFAQR_CMD_SET_CFG      8'h26
`define PFAQR_CMD_GET_ASSIGN   8'h27

// Response type codes.
`define PFAQR_RSP_SET_CFG      8'ha6
`define PFAQR_RSP_GET_ASSIGN   8'ha7

// Channel identifier of a package-addressed command.
`define PFAQR_CHID_PKG_MSB     7
`define PFAQR_CHID_PKG_LSB     5
`define PFAQR_CHID_INTERNAL    5'h1f

// Response and reason codes for a completed command.
`define PFAQR_RSP_CODE_OK      16'h0000
`define PFAQR_REASON_NONE      16'h0000

// Byte offsets inside a response packet.
`define PFAQR_OFS_RESP         8'h10
`define PFAQR_OFS_FIRST_MAP    8'h14
`define PFAQR_OFS_SET_CSUM     8'h14

// Bitmap geometry.
`define PFAQR_MAP_W            32
`define PFAQR_FUNC_ALL         32'hffffffff

`endif

// File: pfaqr_partition_calc.sv
// Registered partition index of one function within one channel bitmap.
`timescale 1ns/1ps
module pfaqr_partition_calc (
   // Clock and reset.
   input  wire logic                      clk_in,
   input  wire logic                      reset_in,
   // Channel bitmap and function number.
   input  wire logic [31:0]               chan_map_in,
   input  wire logic [4:0]                func_in,
   // Result.
   output logic      [4:0]                part_id_out,
   output logic                           part_valid_out
);

   logic [4:0] part_id_ff;
   logic       part_valid_ff;
   logic [4:0] nxt_part_id;
   logic       nxt_part_valid;

   // The index counts the assigned functions below this one, enabled or not.
   always_comb begin
      nxt_part_valid = chan_map_in[func_in];
      nxt_part_id    = 5'(pfaqr_pkg::pfaqr_popcount(chan_map_in & pfaqr_pkg::pfaqr_lowmask({1'b0, func_in})));
   end

   // Result registers.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         part_id_ff    <= 5'h00;
         part_valid_ff <= 1'b0;
      end else begin
         part_id_ff    <= nxt_part_id;
         part_valid_ff <= nxt_part_valid;
      end
   end

   assign part_id_out    = part_id_ff;
   assign part_valid_out = part_valid_ff;

endmodule : pfaqr_partition_calc

// File: pfaqr_pkg.sv
// Types and helper functions shared by the function-assignment query responder.
package pfaqr_pkg;

   // Response sequencer states.
   typedef enum logic [1:0] {
      PFAQR_IDLE,
      PFAQR_SEND,
      PFAQR_DRAIN
   } pfaqr_state_t;

   // Function count or partition index, 0 to 32.
   typedef logic [5:0] pfaqr_count_t;

   // Number of set bits in a function bitmap.
   function automatic pfaqr_count_t pfaqr_popcount(input logic [31:0] map);
      pfaqr_count_t n;
      n = 6'h00;
      for (int i = 0; i < 32; i++) begin
         n = n + pfaqr_count_t'(map[i]);
      end
      return n;
   endfunction : pfaqr_popcount

   // Mask with the lowest count bits set.
   function automatic logic [31:0] pfaqr_lowmask(input pfaqr_count_t count);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 32; i++) begin
         if (6'(i) < count) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction : pfaqr_lowmask

endpackage : pfaqr_pkg

// File: pfaqr_responder.sv
// Package-level responder for set-configuration and function-assignment query commands.
`timescale 1ns/1ps
`include "pfaqr_params.svh"
module pfaqr_responder #(
   parameter int MAX_CHANNELS  = 8,
   parameter int MAX_ENDPOINTS = 8
)(
   // Clock and reset.
   input  wire logic                                  CLK_SYS_IN,
   input  wire logic                                  RESET_IN,
   // Package identity.
   input  wire logic [2:0]                            PACKAGE_ID_IN,
   // Command from the packet parser.
   input  wire logic                                  CMD_VALID_IN,
   input  wire logic [7:0]                            CMD_TYPE_IN,
   input  wire logic [7:0]                            CMD_CHANNEL_ID_IN,
   input  wire logic                                  CMD_CSUM_ERR_IN,
   output logic                                       CMD_READY_OUT,
   // Assignment configuration.
   input  wire logic [MAX_CHANNELS*32-1:0]            CHAN_ASSIGN_IN,
   input  wire logic [31:0]                           PORT_ASSOC_IN,
   input  wire logic [31:0]                           FUNC_ENABLE_IN,
   input  wire logic [MAX_ENDPOINTS*32-1:0]           EP_ASSIGN_IN,
   input  wire logic [7:0]                            ENABLED_PORTS_IN,
   input  wire logic [7:0]                            ENABLED_ENDPOINTS_IN,
   input  wire pfaqr_pkg::pfaqr_count_t               SUPPORTED_FUNCS_IN,
   output pfaqr_pkg::pfaqr_count_t                    ACTIVE_FUNCTION_COUNT_OUT,
   // Response word stream to the packet framer.
   output logic                                       RSP_VALID_OUT,
   input  wire logic                                  RSP_READY_IN,
   output logic [7:0]                                 RSP_TYPE_OUT,
   output logic [7:0]                                 RSP_BYTE_OFS_OUT,
   output logic [31:0]                                RSP_WORD_OUT,
   output logic                                       RSP_CSUM_SLOT_OUT,
   output logic                                       RSP_LAST_OUT,
   // Partition index lookup.
   input  wire logic [4:0]                            PART_CHAN_IN,
   input  wire logic [4:0]                            PART_FUNC_IN,
   output logic [4:0]                                 PART_ID_OUT,
   output logic                                       PART_VALID_OUT
);

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks and declarations.

   // Word index is seven bits and channel numbers five; larger maps cannot be served.
   if (MAX_CHANNELS < 1 || MAX_CHANNELS > 31 || MAX_ENDPOINTS < 1 || MAX_ENDPOINTS > 31) begin : bad_param
      $error("pfaqr_responder: channel or endpoint count out of range");
   end

   pfaqr_pkg::pfaqr_state_t state_ff, nxt_state;
   logic [6:0]              idx_ff, nxt_idx;
   logic [6:0]              n_ch_ff, nxt_n_ch;
   logic [6:0]              n_ep_ff, nxt_n_ep;
   logic                    is_get_ff, nxt_is_get;
   logic                    cmd_ready_ff, nxt_cmd_ready;
   logic                    rsp_valid_ff, nxt_rsp_valid;
   logic [7:0]              rsp_type_ff, nxt_rsp_type;
   logic [7:0]              rsp_ofs_ff, nxt_rsp_ofs;
   logic [31:0]             rsp_word_ff, nxt_rsp_word;
   logic                    rsp_csum_ff, nxt_rsp_csum;
   logic                    rsp_bitmap_ff, nxt_rsp_bitmap;
   pfaqr_pkg::pfaqr_count_t active_cnt_ff, nxt_active_cnt;

   logic        addr_ok;
   logic        known_cmd;
   logic        take_cmd;
   logic        fire;
   logic [6:0]  ports_clamp;
   logic [6:0]  eps_clamp;
   logic [6:0]  assoc_idx;
   logic [6:0]  en_idx;
   logic [6:0]  csum_idx;
   logic [31:0] raw_word;
   logic        raw_bitmap;
   logic        raw_csum;
   logic [31:0] masked_word;
   logic [31:0] en_masked;
   logic [31:0] part_map;

   ////////////////////////////////////////////////////////////////////////////////
   // Command acceptance.

   assign addr_ok = (CMD_CHANNEL_ID_IN[`PFAQR_CHID_PKG_MSB:`PFAQR_CHID_PKG_LSB] == PACKAGE_ID_IN) &&
                    (CMD_CHANNEL_ID_IN[4:0] == `PFAQR_CHID_INTERNAL);
   assign known_cmd = (CMD_TYPE_IN == `PFAQR_CMD_GET_ASSIGN) || (CMD_TYPE_IN == `PFAQR_CMD_SET_CFG);
   // accept unless checksum, identifier or command type fails
   assign take_cmd  = CMD_VALID_IN && cmd_ready_ff && addr_ok && !CMD_CSUM_ERR_IN && known_cmd;
   assign fire      = rsp_valid_ff && RSP_READY_IN;

   // Counts are clamped to what the ports can carry, then frozen for the whole answer.
   always_comb begin
      if (ENABLED_PORTS_IN > 8'(MAX_CHANNELS)) begin
         ports_clamp = 7'(MAX_CHANNELS);
      end else begin
         ports_clamp = ENABLED_PORTS_IN[6:0];
      end
      if (ENABLED_ENDPOINTS_IN > 8'(MAX_ENDPOINTS)) begin
         eps_clamp = 7'(MAX_ENDPOINTS);
      end else begin
         eps_clamp = ENABLED_ENDPOINTS_IN[6:0];
      end
      if (ENABLED_ENDPOINTS_IN <= 8'h01) begin
         eps_clamp = 7'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response word selection.

   assign assoc_idx = n_ch_ff + 7'h01;
   assign en_idx    = n_ch_ff + 7'h02;
   assign csum_idx  = is_get_ff ? (n_ch_ff + 7'h03 + n_ep_ff) : 7'h01;

   // Bitmaps are read live while the answer runs; software should not reassign mid-answer.
   always_comb begin
      raw_word   = 32'h00000000;
      raw_bitmap = 1'b0;
      raw_csum   = 1'b0;
      if (idx_ff == 7'h00) begin
         raw_word = {`PFAQR_RSP_CODE_OK, `PFAQR_REASON_NONE};
      end else if (idx_ff == csum_idx) begin
         raw_csum = 1'b1;
      end else if (idx_ff <= n_ch_ff) begin
         raw_bitmap = 1'b1;
         for (int c = 0; c < MAX_CHANNELS; c++) begin
            if (idx_ff == 7'(c + 1)) begin
               raw_word = CHAN_ASSIGN_IN[c*32 +: 32];
            end
         end
      end else if (idx_ff == assoc_idx) begin
         raw_bitmap = 1'b1;
         raw_word   = PORT_ASSOC_IN;
      end else if (idx_ff == en_idx) begin
         raw_bitmap = 1'b1;
         // enable map is independent of channel maps
         raw_word   = FUNC_ENABLE_IN;
      end else begin
         raw_bitmap = 1'b1;
         for (int e = 0; e < MAX_ENDPOINTS; e++) begin
            if (idx_ff == en_idx + 7'(e + 1)) begin
               raw_word = EP_ASSIGN_IN[e*32 +: 32];
            end
         end
      end
   end

   pfaqr_func_mask u_word_mask (
      .word_in       (raw_word),
      .is_bitmap_in  (raw_bitmap),
      .func_count_in (SUPPORTED_FUNCS_IN),
      .word_out      (masked_word)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Response sequencer.

   // One word is loaded whenever the output register is empty or being drained.
   always_comb begin
      nxt_state      = state_ff;
      nxt_idx        = idx_ff;
      nxt_n_ch       = n_ch_ff;
      nxt_n_ep       = n_ep_ff;
      nxt_is_get     = is_get_ff;
      nxt_rsp_valid  = rsp_valid_ff;
      nxt_rsp_type   = rsp_type_ff;
      nxt_rsp_ofs    = rsp_ofs_ff;
      nxt_rsp_word   = rsp_word_ff;
      nxt_rsp_csum   = rsp_csum_ff;
      nxt_rsp_bitmap = rsp_bitmap_ff;
      unique case (state_ff)
         pfaqr_pkg::PFAQR_IDLE: begin
            if (take_cmd) begin
               nxt_state  = pfaqr_pkg::PFAQR_SEND;
               nxt_idx    = 7'h00;
               nxt_is_get = (CMD_TYPE_IN == `PFAQR_CMD_GET_ASSIGN);
               nxt_n_ch   = ports_clamp;
               nxt_n_ep   = eps_clamp;
               if (CMD_TYPE_IN == `PFAQR_CMD_GET_ASSIGN) begin
                  nxt_rsp_type = `PFAQR_RSP_GET_ASSIGN;
               end else begin
                  nxt_rsp_type = `PFAQR_RSP_SET_CFG;
               end
            end
         end
         pfaqr_pkg::PFAQR_SEND: begin
            if (!rsp_valid_ff || fire) begin
               nxt_rsp_valid  = 1'b1;
               nxt_rsp_word   = masked_word;
               nxt_rsp_bitmap = raw_bitmap;
               nxt_rsp_csum   = raw_csum;
               nxt_rsp_ofs    = `PFAQR_OFS_RESP + {idx_ff[5:0], 2'b00};
               nxt_idx        = idx_ff + 7'h01;
               if (raw_csum) begin
                  nxt_state = pfaqr_pkg::PFAQR_DRAIN;
               end
            end
         end
         pfaqr_pkg::PFAQR_DRAIN: begin
            if (fire) begin
               nxt_rsp_valid = 1'b0;
               nxt_state     = pfaqr_pkg::PFAQR_IDLE;
            end
         end
      endcase
      nxt_cmd_ready = (nxt_state == pfaqr_pkg::PFAQR_IDLE);
   end

   // Sequencer registers.
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         state_ff      <= pfaqr_pkg::PFAQR_IDLE;
         idx_ff        <= 7'h00;
         n_ch_ff       <= 7'h00;
         n_ep_ff       <= 7'h00;
         is_get_ff     <= 1'b0;
         cmd_ready_ff  <= 1'b1;
         rsp_valid_ff  <= 1'b0;
         rsp_type_ff   <= 8'h00;
         rsp_ofs_ff    <= 8'h00;
         rsp_word_ff   <= 32'h00000000;
         rsp_csum_ff   <= 1'b0;
         rsp_bitmap_ff <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         idx_ff        <= nxt_idx;
         n_ch_ff       <= nxt_n_ch;
         n_ep_ff       <= nxt_n_ep;
         is_get_ff     <= nxt_is_get;
         cmd_ready_ff  <= nxt_cmd_ready;
         rsp_valid_ff  <= nxt_rsp_valid;
         rsp_type_ff   <= nxt_rsp_type;
         rsp_ofs_ff    <= nxt_rsp_ofs;
         rsp_word_ff   <= nxt_rsp_word;
         rsp_csum_ff   <= nxt_rsp_csum;
         rsp_bitmap_ff <= nxt_rsp_bitmap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Active function count and partition lookup.

   assign en_masked = FUNC_ENABLE_IN & pfaqr_pkg::pfaqr_lowmask(SUPPORTED_FUNCS_IN);
   always_comb begin
      nxt_active_cnt = pfaqr_pkg::pfaqr_popcount(en_masked);
   end

   // Count register.
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         active_cnt_ff <= 6'h00;
      end else begin
         active_cnt_ff <= nxt_active_cnt;
      end
   end

   // Out-of-range channels look up an empty map, so the lookup reports no partition.
   always_comb begin
      part_map = 32'h00000000;
      for (int c = 0; c < MAX_CHANNELS; c++) begin
         if (PART_CHAN_IN == 5'(c)) begin
            part_map = CHAN_ASSIGN_IN[c*32 +: 32] & pfaqr_pkg::pfaqr_lowmask(SUPPORTED_FUNCS_IN);
         end
      end
   end

   pfaqr_partition_calc u_part (
      .clk_in         (CLK_SYS_IN),
      .reset_in       (RESET_IN),
      .chan_map_in    (part_map),
      .func_in        (PART_FUNC_IN),
      .part_id_out    (PART_ID_OUT),
      .part_valid_out (PART_VALID_OUT)
   );

   assign CMD_READY_OUT             = cmd_ready_ff;
   assign ACTIVE_FUNCTION_COUNT_OUT = active_cnt_ff;
   assign RSP_VALID_OUT             = rsp_valid_ff;
   assign RSP_TYPE_OUT              = rsp_type_ff;
   assign RSP_BYTE_OFS_OUT          = rsp_ofs_ff;
   assign RSP_WORD_OUT              = rsp_word_ff;
   assign RSP_CSUM_SLOT_OUT         = rsp_csum_ff;
   assign RSP_LAST_OUT              = rsp_csum_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RESET_IN);

   bad_id_drop_a : assert property ((CMD_VALID_IN && CMD_READY_OUT && !addr_ok) |=> CMD_READY_OUT)
      else $error("misaddressed command was taken");
   set_answer_a : assert property ((take_cmd && CMD_TYPE_IN == `PFAQR_CMD_SET_CFG) |-> ##2 (RSP_VALID_OUT && RSP_TYPE_OUT == `PFAQR_RSP_SET_CFG))
      else $error("set-config command not answered in two cycles");
   get_type_a : assert property ((RSP_VALID_OUT && is_get_ff) |-> RSP_TYPE_OUT == `PFAQR_RSP_GET_ASSIGN)
      else $error("query answer carries wrong type");
   first_word_a : assert property ($rose(RSP_VALID_OUT) |-> (RSP_BYTE_OFS_OUT == `PFAQR_OFS_RESP && RSP_WORD_OUT == {`PFAQR_RSP_CODE_OK, `PFAQR_REASON_NONE}))
      else $error("first answer word wrong");
   set_csum_a : assert property ((RSP_VALID_OUT && RSP_CSUM_SLOT_OUT && !is_get_ff) |-> RSP_BYTE_OFS_OUT == `PFAQR_OFS_SET_CSUM)
      else $error("set-config checksum slot at wrong offset");
   get_csum_a : assert property ((RSP_VALID_OUT && RSP_CSUM_SLOT_OUT && is_get_ff) |-> RSP_BYTE_OFS_OUT == `PFAQR_OFS_FIRST_MAP + {n_ch_ff[5:0] + 6'h02 + n_ep_ff[5:0], 2'b00})
      else $error("query checksum slot at wrong offset");
   func_mask_a : assert property ((RSP_VALID_OUT && rsp_bitmap_ff) |-> (RSP_WORD_OUT & ~pfaqr_pkg::pfaqr_lowmask(SUPPORTED_FUNCS_IN)) == 32'h00000000)
      else $error("bitmap bit set beyond supported functions");
   active_count_a : assert property (##1 ACTIVE_FUNCTION_COUNT_OUT == pfaqr_pkg::pfaqr_popcount($past(FUNC_ENABLE_IN) & pfaqr_pkg::pfaqr_lowmask($past(SUPPORTED_FUNCS_IN))))
      else $error("active function count differs from enable map");
   stall_hold_a : assert property ((RSP_VALID_OUT && !RSP_READY_IN) |=> (RSP_VALID_OUT && $stable(RSP_WORD_OUT) && $stable(RSP_BYTE_OFS_OUT)))
      else $error("answer word changed while stalled");
   busy_ready_a : assert property ((state_ff != pfaqr_pkg::PFAQR_IDLE) |-> !CMD_READY_OUT)
      else $error("ready raised while answering");

endmodule : pfaqr_responder

// File: test_pfaqr_responder.sv
// Self-checking bench for the function-assignment query responder.
`timescale 1ns/1ps
`include "pfaqr_params.svh"
module test_pfaqr_responder;
   localparam int NCH = 4;
   localparam int NEP = 3;
   // Stimulus, given values at time zero.
   logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_err = 1'b0, stall = 1'b0;
   logic [2:0] pkg = 3'h0;
   logic [7:0] cmd_type = 8'h00, cmd_chid = 8'h00, en_ports = 8'h01, en_eps = 8'h00;
   logic [NCH*32-1:0] chan = '0;
   logic [NEP*32-1:0] eps = '0;
   logic [31:0] assoc = 32'h0, enab = 32'h0;
   pfaqr_pkg::pfaqr_count_t sup = 6'h20, active;
   logic [4:0] part_chan = 5'h00, part_func = 5'h00, part_id;
   // Responder outputs and bench state.
   logic cmd_ready, rsp_valid, rsp_ready, rsp_csum, rsp_last, part_valid;
   logic [7:0] rsp_type, rsp_ofs;
   logic [31:0] rsp_word;
   logic [15:0] lfsr_ff = 16'ha833;
   int err_total = 0, checked = 0;

   always #20 clk = ~clk;
   pfaqr_responder #(.MAX_CHANNELS(NCH), .MAX_ENDPOINTS(NEP)) dut_u (
      .CLK_SYS_IN(clk), .RESET_IN(reset), .PACKAGE_ID_IN(pkg), .CMD_VALID_IN(cmd_valid),
      .CMD_TYPE_IN(cmd_type), .CMD_CHANNEL_ID_IN(cmd_chid), .CMD_CSUM_ERR_IN(cmd_err),
      .CMD_READY_OUT(cmd_ready), .CHAN_ASSIGN_IN(chan), .PORT_ASSOC_IN(assoc), .FUNC_ENABLE_IN(enab),
      .EP_ASSIGN_IN(eps), .ENABLED_PORTS_IN(en_ports), .ENABLED_ENDPOINTS_IN(en_eps),
      .SUPPORTED_FUNCS_IN(sup), .ACTIVE_FUNCTION_COUNT_OUT(active), .RSP_VALID_OUT(rsp_valid),
      .RSP_READY_IN(rsp_ready), .RSP_TYPE_OUT(rsp_type), .RSP_BYTE_OFS_OUT(rsp_ofs),
      .RSP_WORD_OUT(rsp_word), .RSP_CSUM_SLOT_OUT(rsp_csum), .RSP_LAST_OUT(rsp_last),
      .PART_CHAN_IN(part_chan), .PART_FUNC_IN(part_func), .PART_ID_OUT(part_id),
      .PART_VALID_OUT(part_valid));
   pfaqr_mgmt_model mc_u (
      .clk_in(clk), .stall_in(stall), .valid_in(rsp_valid), .type_in(rsp_type), .ofs_in(rsp_ofs),
      .word_in(rsp_word), .csum_in(rsp_csum), .last_in(rsp_last), .ready_out(rsp_ready));

   //////////////////////////////////////////////////
   // Bits of a word at and above n are cleared.
   function automatic logic [31:0] mask(input logic [31:0] w, input int n);
      logic [31:0] m;
      for (int i = 0; i < 32; i++) m[i] = w[i] & (i < n);
      return m;
   endfunction : mask
   // Number of set bits below position n.
   function automatic int below(input logic [31:0] w, input int n);
      int k;
      k = 0;
      for (int i = 0; i < n; i++) k += int'(w[i]);
      return k;
   endfunction : below
   // Two register steps give one random word.
   task automatic rnd(output logic [31:0] v);
      for (int i = 0; i < 2; i++) begin
         lfsr_ff = {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
         v = {v[15:0], lfsr_ff};
      end
   endtask : rnd
   // Compare tasks for words and for small fields.
   task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask : chk_word
   task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
      chk_word(name, {24'h0, e}, {24'h0, g});
   endtask : chk_byte
   // Closing report and verdict.
   task automatic end_sim;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   //////////////////////////////////////////////////
   // Hold a command for one edge, or six edges when it should be refused, then wait for idle.
   task automatic send_cmd(input logic [7:0] typ, input logic [7:0] chid, input logic err, input bit good);
      int n;
      n = 0;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_type = typ;
      cmd_chid = chid;
      cmd_err = err;
      repeat (good ? 1 : 6) @(posedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_err = 1'b0;
      chk_byte("ready", {7'h0, !good}, {7'h0, cmd_ready});
      while (cmd_ready !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk_byte("idle", 8'h01, {7'h0, cmd_ready});
   endtask : send_cmd
   // Compare the logged packet with the layout expected from the configuration.
   task automatic check_rsp(input logic [7:0] typ);
      logic [31:0] x[$];
      logic [49:0] e;
      int c, b;
      c = en_ports > NCH ? NCH : int'(en_ports);
      b = en_eps > NEP ? NEP : int'(en_eps);
      x.push_back(32'h0);
      if (typ == `PFAQR_RSP_GET_ASSIGN) begin
         for (int i = 0; i < c; i++) x.push_back(mask(chan[i*32+:32], sup));
         x.push_back(mask(assoc, sup));
         x.push_back(mask(enab, sup));
         for (int i = 0; i < b && b > 1; i++) x.push_back(mask(eps[i*32+:32], sup));
      end
      x.push_back(32'h0);
      chk_byte("words", 8'(x.size()), 8'(mc_u.log_q.size()));
      foreach (x[k]) begin
         e = mc_u.log_q[k];
         chk_byte("type", typ, e[49:42]);
         chk_byte("offset", 8'(16 + 4 * k), e[41:34]);
         chk_byte("last", {6'h0, {2{k == x.size() - 1}}}, {6'h0, e[33:32]});
         chk_word("word", x[k], e[31:0]);
      end
      mc_u.log_q.delete();
   endtask : check_rsp
   // One partition lookup, answered one cycle later.
   task automatic check_part(input logic [4:0] ch, input logic [4:0] f);
      logic [31:0] m;
      @(negedge clk);
      part_chan = ch;
      part_func = f;
      @(negedge clk);
      m = ch < NCH ? mask(chan[ch*32+:32], sup) : 32'h0;
      chk_byte("part_id", 8'(below(m, f)), {3'h0, part_id});
      chk_byte("part_valid", {7'h0, m[f]}, {7'h0, part_valid});
   endtask : check_part

   //////////////////////////////////////////////////
   // Main sequence: random configurations with fixed corners in the first two tests.
   initial begin
      logic [31:0] r;
      repeat (5) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      chk_byte("reset", 8'h02, {6'h0, cmd_ready, rsp_valid});
      for (int t = 0; t < 16; t++) begin
         rnd(r);
         pkg = r[2:0];
         stall = r[3];
         en_ports = {5'h0, r[6:4]};
         en_eps = {5'h0, r[9:7]};
         sup = t == 0 ? 6'h20 : t == 1 ? 6'h00 : 6'(r[15:10] % 33);
         repeat (NCH) begin
            rnd(r);
            chan = {chan[NCH*32-33:0], r};
         end
         repeat (NEP) begin
            rnd(r);
            eps = {eps[NEP*32-33:0], r};
         end
         rnd(assoc);
         rnd(enab);
         if (t == 0) chan[96+:32] = 32'h00000044;
         send_cmd(`PFAQR_CMD_SET_CFG, {pkg, 5'h1f}, 1'b0, 1'b1);
         check_rsp(`PFAQR_RSP_SET_CFG);
         send_cmd(`PFAQR_CMD_GET_ASSIGN, {pkg, 5'h1f}, 1'b0, 1'b1);
         check_rsp(`PFAQR_RSP_GET_ASSIGN);
         send_cmd(`PFAQR_CMD_GET_ASSIGN, {pkg + 3'h1, 5'h1f}, 1'b0, 1'b0);
         send_cmd(`PFAQR_CMD_SET_CFG, {pkg, 5'h1e}, 1'b0, 1'b0);
         send_cmd(`PFAQR_CMD_GET_ASSIGN, {pkg, 5'h1f}, 1'b1, 1'b0);
         send_cmd(8'h28, {pkg, 5'h1f}, 1'b0, 1'b0);
         chk_byte("refused", 8'h00, 8'(mc_u.log_q.size()));
         for (int i = 0; i < 6; i++) begin
            rnd(r);
            check_part(t == 0 ? 5'h03 : {2'h0, r[2:0]}, t == 0 ? 5'(2 + 4 * i) : r[8:4]);
         end
         chk_byte("active", 8'(below(mask(enab, sup), 32)), {2'h0, active});
         $display("test %0d done", t);
      end
      end_sim;
   end
   // Watchdog at twenty times the expected run of about 1000 cycles.
   initial begin
      #(40 * 20000);
      err_total++;
      end_sim;
   end
endmodule : test_pfaqr_responder
